//--- qdac_pkg.sv
// constants and types shared by the quad dac register decoder
`default_nettype none
package qdac_pkg;
   // command word layout
   localparam int FRAME_BITS = 24;
   localparam int CNT_W = 5;
   localparam int NUM_CH = 4;
   localparam int CODE_W = 16;
   localparam int RANGE_W = 2;
   localparam int GAIN_W = 6;
   localparam int OFFS_W = 8;
   // register-select codes
   localparam logic [2:0] RSEL_FUNC = 3'h0;
   localparam logic [2:0] RSEL_DATA = 3'h2;
   localparam logic [2:0] RSEL_RANGE = 3'h3;
   localparam logic [2:0] RSEL_GAIN = 3'h4;
   localparam logic [2:0] RSEL_OFFS = 3'h5;
   // function codes carried in the channel-select field
   localparam logic [2:0] FUNC_NOP = 3'h0;
   localparam logic [2:0] FUNC_CTRL = 3'h1;
   localparam logic [2:0] FUNC_CLEAR = 3'h4;
   localparam logic [2:0] FUNC_LOAD = 3'h5;
   // channel-select code that hits all four channels
   localparam logic [2:0] CSEL_ALL = 3'h4;
   // control_options bit positions
   localparam int CTL_LGO = 5;
   localparam int CTL_DIR1 = 4;
   localparam int CTL_VAL1 = 3;
   localparam int CTL_DIR0 = 2;
   localparam int CTL_VAL0 = 1;
   localparam int CTL_SDO_DIS = 0;
   // reset values and the range code left undefined
   localparam logic [5:0] CTL_RESET = 6'h00;
   localparam logic [1:0] RANGE_RESET = 2'h0;
   localparam logic [1:0] RANGE_UNDEF = 2'h3;
   localparam logic [5:0] GAIN_RESET = 6'h00;
   localparam logic [7:0] OFFS_RESET = 8'h00;
   localparam logic [15:0] CODE_RESET = 16'h0000;
   // zero code in two's complement and negative full scale in offset binary coincide
   localparam logic [15:0] CLEAR_CODE = 16'h0000;

   typedef struct packed {
      logic rw;
      logic zero;
      logic [2:0] rsel;
      logic [2:0] csel;
      logic [15:0] data;
   } qdac_cmd_t;

   typedef struct packed {
      logic [15:0] code;
      logic [1:0] range;
      logic [5:0] gain;
      logic [7:0] offs;
   } qdac_chan_t;
endpackage
`default_nettype wire

//--- qdac_decoder.sv
// serial command decoder and register bank of the quad dac
`default_nettype none
// Behaviour
// - register-select 000 routes to control_options; channel-select picks the function.
// - function 000 is a no-operation; data ignored.
// - no-operation is the accepted filler word during readback frames.
// - function 001 data: bit5 lgo, bits4/3 pin one, bits2/1 pin zero, bit0 sdo off.
// - local ground offset enable, one enables, resets disabled.
// - direction bit one makes pin an output; both pins reset to input.
// - output pins drive the last written value bit.
// - input pins read back live level; value writes ignored.
// - sdo disable bit one turns serial output off; resets enabled.
// - function 100 is clear; data ignored.
// - clear forces dac codes to the zero / negative full-scale code.
// - function 101 loads input registers into dac registers; data ignored.
// - register-select 010 writes the 16-bit channel code.
// - register-select 011 writes 2-bit range select from bits 1:0.
// - range codes 00, 01, 10 select the three output ranges.
// - register-select 100 writes 6-bit gain trim from bits 5:0.
// - gain trim is two's complement +31..-32, resets to zero.
// - each gain step moves both full-scale points by half a step.
// - register-select 101 writes 8-bit offset trim from bits 7:0.
// - offset trim two's complement in eighth-lsb steps, resets zero.
// - frames are 24 bits: rw, zero, register-select, channel-select, data.
// - channel-select 000..011 picks one channel, 100 picks all.
module qdac_decoder (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic sclk_i,
   input wire logic sync_n_i,
   input wire logic sdin_i,
   output logic sdo_o,
   output logic sdo_oe_n_o,
   input wire logic [1:0] port_pin_i,
   output logic [1:0] port_pin_o,
   output logic [1:0] port_pin_oe_n_o,
   output logic lgo_en_o,
   output qdac_pkg::qdac_chan_t [3:0] chan_cfg_o,
   output logic [3:0][15:0] dac_code_o,
   output logic load_o,
   output logic clear_o
);
   import qdac_pkg::*;

   // two-stage synchronisers, plus a third stage for edge detection
   logic [2:0] meta_q, sync_q;
   logic [1:0] prev_q;
   logic [1:0] pin_meta_q, pin_sync_q;
   logic [CNT_W-1:0] cnt_q;
   logic [FRAME_BITS-1:0] sh_q;
   logic [FRAME_BITS-1:0] rd_word_q, sdo_sh_q;
   logic rd_pend_q;
   logic [5:0] ctl_q;
   qdac_chan_t [3:0] in_q;
   logic [3:0][15:0] dac_q;
   logic sdo_q, load_q, clear_q;

   // matches a channel index against channel-select, honouring the all code
   function automatic logic chan_hit(input logic [2:0] csel, input int idx);
      chan_hit = (csel == CSEL_ALL) || (csel == 3'(idx));
   endfunction

   // synchronised link signals and their edges
   wire sclk_s = sync_q[0];
   wire sync_s = sync_q[1];
   wire sdin_s = sync_q[2];
   wire sclk_fall = en_i && prev_q[0] && !sclk_s;
   wire sclk_rise = en_i && !prev_q[0] && sclk_s;
   wire sync_fall = en_i && prev_q[1] && !sync_s;
   wire sync_rise = en_i && !prev_q[1] && sync_s;

   // a frame counts only when exactly 24 bits arrived
   qdac_cmd_t cmd;
   assign cmd = qdac_cmd_t'(sh_q);
   wire commit = sync_rise && (cnt_q == CNT_W'(FRAME_BITS));
   wire wr = commit && !cmd.rw && !cmd.zero;
   wire rd = commit && cmd.rw && !cmd.zero;
   wire is_func = cmd.rsel == RSEL_FUNC;
   wire f_ctrl = wr && is_func && cmd.csel == FUNC_CTRL;
   wire f_clear = wr && is_func && cmd.csel == FUNC_CLEAR;
   wire f_load = wr && is_func && cmd.csel == FUNC_LOAD;
   wire ch_ok = cmd.csel <= CSEL_ALL;
   wire w_data = wr && ch_ok && cmd.rsel == RSEL_DATA;
   wire w_range = wr && ch_ok && cmd.rsel == RSEL_RANGE
                  && cmd.data[1:0] != RANGE_UNDEF;
   wire w_gain = wr && ch_ok && cmd.rsel == RSEL_GAIN;
   wire w_offs = wr && ch_ok && cmd.rsel == RSEL_OFFS;

   // value bits move only where the written direction is output
   wire [1:0] new_dir = {cmd.data[CTL_DIR1], cmd.data[CTL_DIR0]};
   wire val1_d = new_dir[1] ? cmd.data[CTL_VAL1] : ctl_q[CTL_VAL1];
   wire val0_d = new_dir[0] ? cmd.data[CTL_VAL0] : ctl_q[CTL_VAL0];
   wire [5:0] ctl_d = {cmd.data[CTL_LGO], new_dir[1], val1_d,
                       new_dir[0], val0_d, cmd.data[CTL_SDO_DIS]};

   // readback view: input pins show their live level
   wire [5:0] ctl_rd = {ctl_q[CTL_LGO], ctl_q[CTL_DIR1],
                        ctl_q[CTL_DIR1] ? ctl_q[CTL_VAL1] : pin_sync_q[1],
                        ctl_q[CTL_DIR0],
                        ctl_q[CTL_DIR0] ? ctl_q[CTL_VAL0] : pin_sync_q[0],
                        ctl_q[CTL_SDO_DIS]};
   // an all-channel read returns channel a
   wire [1:0] rd_ch = cmd.csel[1:0] & {2{cmd.csel != CSEL_ALL}};
   logic [15:0] rd_data;
   always_comb begin
      case (cmd.rsel)
         RSEL_FUNC: rd_data = {10'h000, ctl_rd};
         RSEL_DATA: rd_data = in_q[rd_ch].code;
         RSEL_RANGE: rd_data = {14'h0000, in_q[rd_ch].range};
         RSEL_GAIN: rd_data = {10'h000, in_q[rd_ch].gain};
         RSEL_OFFS: rd_data = {8'h00, in_q[rd_ch].offs};
         default: rd_data = 16'h0000;
      endcase
   end

   // pin and link synchronisers; the first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         meta_q <= 3'h3;
         sync_q <= 3'h3;
         prev_q <= 2'h3;
         pin_meta_q <= 2'h0;
         pin_sync_q <= 2'h0;
      end else if (en_i) begin
         meta_q <= {sdin_i, sync_n_i, sclk_i};
         sync_q <= meta_q;
         prev_q <= sync_q[1:0];
         pin_meta_q <= port_pin_i;
         pin_sync_q <= pin_meta_q;
      end
   end

   // input shift register, data taken on falling serial clock inside a frame
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sh_q <= '0;
         cnt_q <= '0;
      end else if (sync_fall) begin
         cnt_q <= '0;
      end else if (sclk_fall && !sync_s) begin
         sh_q <= {sh_q[FRAME_BITS-2:0], sdin_s};
         cnt_q <= (cnt_q == '1) ? cnt_q : cnt_q + CNT_W'(1); // overlong frames saturate
      end
   end

   // readback: a read frame arms a word that the next frame (nop filler) shifts out
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rd_word_q <= '0;
         rd_pend_q <= 1'b0;
         sdo_sh_q <= '0;
         sdo_q <= 1'b0;
      end else if (rd) begin
         rd_word_q <= {cmd.rw, cmd.zero, cmd.rsel, cmd.csel, rd_data};
         rd_pend_q <= 1'b1;
      end else if (sync_fall) begin
         sdo_sh_q <= rd_pend_q ? rd_word_q : '0;
         sdo_q <= rd_pend_q & rd_word_q[FRAME_BITS-1];
         rd_pend_q <= 1'b0;
      end else if (sclk_rise && !sync_s) begin
         sdo_sh_q <= {sdo_sh_q[FRAME_BITS-2:0], 1'b0};
         sdo_q <= sdo_sh_q[FRAME_BITS-2];
      end
   end

   // control options; nop, clear and load leave it alone
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ctl_q <= CTL_RESET;
      end else if (f_ctrl) begin
         ctl_q <= ctl_d;
      end
   end

   // per-channel input registers; one decode serves one or all channels
   // trims are stored raw; the analog side applies half-step gain and eighth-lsb offset
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < NUM_CH; i++) begin
            in_q[i] <= {CODE_RESET, RANGE_RESET, GAIN_RESET, OFFS_RESET};
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (chan_hit(cmd.csel, i)) begin
               if (w_data) in_q[i].code <= cmd.data;
               if (w_range) in_q[i].range <= cmd.data[1:0];
               if (w_gain) in_q[i].gain <= cmd.data[5:0];
               if (w_offs) in_q[i].offs <= cmd.data[7:0];
            end
         end
      end
   end

   // dac registers: clear wins over load, though both cannot come at once
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         dac_q <= '0;
         load_q <= 1'b0;
         clear_q <= 1'b0;
      end else if (en_i) begin
         load_q <= f_load;
         clear_q <= f_clear;
         for (int i = 0; i < NUM_CH; i++) begin
            if (f_clear) dac_q[i] <= CLEAR_CODE;
            else if (f_load) dac_q[i] <= in_q[i].code;
         end
      end
   end

   // outputs straight from flip-flops
   assign sdo_o = sdo_q;
   assign sdo_oe_n_o = ctl_q[CTL_SDO_DIS];
   assign port_pin_o = {ctl_q[CTL_VAL1], ctl_q[CTL_VAL0]};
   assign port_pin_oe_n_o = ~{ctl_q[CTL_DIR1], ctl_q[CTL_DIR0]};
   assign lgo_en_o = ctl_q[CTL_LGO];
   assign chan_cfg_o = in_q;
   assign dac_code_o = dac_q;
   assign load_o = load_q;
   assign clear_o = clear_q;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   // function register: only function 001 may touch the options
   a_nop_no_change: assert property (commit && is_func && cmd.csel == FUNC_NOP
      |=> $stable(ctl_q) && $stable(in_q) && $stable(dac_q))
      else $error("nop changed state");
   a_ctl_write: assert property (f_ctrl
      |=> lgo_en_o == $past(cmd.data[CTL_LGO])
      && sdo_oe_n_o == $past(cmd.data[CTL_SDO_DIS]))
      else $error("control bits not taken");
   a_ctl_hold: assert property (commit && !f_ctrl |=> $stable(ctl_q))
      else $error("control options changed by another command");
   a_pin_oe: assert property (f_ctrl
      |=> port_pin_oe_n_o == ~$past({cmd.data[CTL_DIR1], cmd.data[CTL_DIR0]}))
      else $error("pin direction not taken");
   a_pin_drive: assert property (f_ctrl && cmd.data[CTL_DIR0]
      |=> !port_pin_oe_n_o[0] && port_pin_o[0] == $past(cmd.data[CTL_VAL0]))
      else $error("pin zero not driven with value");
   a_val1_write: assert property (f_ctrl && cmd.data[CTL_DIR1]
      |=> port_pin_o[1] == $past(cmd.data[CTL_VAL1]))
      else $error("pin one value not taken");
   a_pin_input: assert property (f_ctrl && !cmd.data[CTL_DIR1]
      |=> port_pin_oe_n_o[1] && $stable(port_pin_o[1]))
      else $error("input pin value changed");

   // dac registers move only on load or clear, and the pulse lands with them
   a_clear_zero: assert property (f_clear |=> dac_code_o == '0 && clear_o)
      else $error("clear did not zero dac");
   a_clear_keeps: assert property (f_clear |=> $stable(in_q))
      else $error("clear touched the input registers");
   a_load_copy: assert property (f_load
      |=> dac_code_o[3] == $past(in_q[3].code) && dac_code_o[0] == $past(in_q[0].code))
      else $error("load did not copy");
   a_load_pulse: assert property (load_o |=> !load_o)
      else $error("load pulse longer than one cycle");
   a_dac_hold: assert property (!f_load && !f_clear |=> $stable(dac_code_o))
      else $error("dac code moved without a command");

   // per-channel registers
   a_all_write: assert property (w_range && cmd.csel == CSEL_ALL
      |=> chan_cfg_o[0].range == $past(cmd.data[1:0])
      && chan_cfg_o[3].range == $past(cmd.data[1:0]))
      else $error("all-channel write missed a channel");
   a_data_write: assert property (w_data && cmd.csel == 3'h1
      |=> chan_cfg_o[1].code == $past(cmd.data) ##1 $stable(chan_cfg_o[1].code)[*2])
      else $error("data write not held");
   a_gain_one: assert property (w_gain && cmd.csel == 3'h3
      |=> chan_cfg_o[3].gain == $past(cmd.data[5:0]) && $stable(chan_cfg_o[2].gain))
      else $error("gain write missed or spread");
   a_offs_write: assert property (w_offs && cmd.csel == 3'h0
      |=> chan_cfg_o[0].offs == $past(cmd.data[7:0]))
      else $error("offset write not taken");
   a_range_refused: assert property (wr && cmd.rsel == RSEL_RANGE
      && cmd.data[1:0] == RANGE_UNDEF |=> $stable(in_q))
      else $error("undefined range code taken");
   a_undef_ignored: assert property (wr && (cmd.rsel == 3'h1 || cmd.rsel > RSEL_OFFS
      || (!is_func && cmd.csel > CSEL_ALL)
      || (is_func && (cmd.csel == 3'h2 || cmd.csel == 3'h3 || cmd.csel > FUNC_LOAD)))
      |=> $stable(ctl_q) && $stable(in_q) && $stable(dac_q))
      else $error("undefined code changed state");

   // link: short frames are dropped, readback shifts one bit per rising serial clock
   a_short_frame: assert property (sync_rise && cnt_q != CNT_W'(FRAME_BITS)
      |=> $stable(ctl_q) && $stable(in_q) && $stable(dac_q))
      else $error("short frame changed state");
   a_sdo_first: assert property (sync_fall && rd_pend_q
      |=> sdo_o == $past(rd_word_q[FRAME_BITS-1]))
      else $error("readback first bit wrong");
   a_sdo_idle: assert property (sync_fall && !rd_pend_q |=> !sdo_o)
      else $error("sdo not zero without a pending read");
   a_sdo_shift: assert property (sclk_rise && !sync_s && !sync_fall
      |=> sdo_o == $past(sdo_sh_q[FRAME_BITS-2]))
      else $error("readback bit not advanced");

   // main scenarios
   c_read_frame: cover property (rd ##[1:300] sync_fall);
   c_load: cover property (w_data ##[1:300] f_load);
   c_pin_out: cover property (f_ctrl && cmd.data[CTL_DIR1]);
   c_clear: cover property (f_clear ##1 clear_o);
endmodule
`default_nettype wire

//--- qdac_host.sv
// host controller model driving the serial programming link
`default_nettype none
module qdac_host (
   input wire logic clk_i,
   output logic sclk_o,
   output logic sync_n_o,
   output logic sdin_o,
   input wire logic sdo_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // sclk stands still high between frames, frame select released
   initial begin
      sclk_o = 1'b1;
      sync_n_o = 1'b1;
      sdin_o = 1'b0;
   end
   // wait n system clocks and land just after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // one frame msb first, nbits long; rx gets what sdo shifted out meanwhile
   task automatic frame(input logic [23:0] w, input int nbits, output logic [23:0] rx);
      sync_n_o = 1'b0;
      tick(5);
      for (int i = 23; i >= 24 - nbits; i--) begin
         sdin_o = w[i];
         tick(5);
         rx[i] = sdo_i;
         sclk_o = 1'b0;
         tick(5);
         sclk_o = 1'b1;
      end
      tick(5);
      sync_n_o = 1'b1;
      // a released data line must not keep showing its last bit
      sdin_o = ~sdin_o;
      tick(8);
   endtask
endmodule
`default_nettype wire

//--- qdac_tb.sv
// self-checking bench for the quad dac register decoder
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import qdac_pkg::*;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic sclk, sync_n, sdin, sdo, sdo_oe_n, sdo_w, lgo, load, clear;
   logic [1:0] ext_pin = 2'b10;
   logic [1:0] pin_w, pin_o, pin_oe_n;
   qdac_chan_t [3:0] cfg;
   logic [3:0][15:0] dac;
   logic [23:0] rx;
   int num_errors = 0;
   int n_tests = 0;
   int n_load = 0;
   int n_clear = 0;
   always #4 clk_i = ~clk_i;
   // sdo has no pull, so a released line shows the inverse of its last value
   assign sdo_w = sdo_oe_n ? ~sdo : sdo;
   // port pins: the design wins where it drives, else the outside level
   assign pin_w = (pin_oe_n & ext_pin) | (~pin_oe_n & pin_o);
   // count command pulses so a missing or doubled one shows up
   always @(negedge clk_i) begin
      if (load === 1'b1) n_load++;
      if (clear === 1'b1) n_clear++;
   end
   qdac_decoder DUT (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(1'b1), .sclk_i(sclk),
      .sync_n_i(sync_n), .sdin_i(sdin), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
      .port_pin_i(pin_w), .port_pin_o(pin_o), .port_pin_oe_n_o(pin_oe_n),
      .lgo_en_o(lgo), .chan_cfg_o(cfg), .dac_code_o(dac), .load_o(load),
      .clear_o(clear));
   qdac_host host (.clk_i(clk_i), .sclk_o(sclk), .sync_n_o(sync_n), .sdin_o(sdin),
      .sdo_i(sdo_w));
   task automatic wr(input logic [23:0] w);
      host.frame(w, 24, rx);
   endtask
   task automatic t_reset();
      for (int c = 0; c < 4; c++) `CHK(cfg[c], {CODE_RESET, 16'h0000})
      `CHK({lgo, sdo_oe_n, pin_oe_n}, 4'b0011)
   endtask
   // one channel, all channels, and each trim field with junk in the upper bits
   task automatic t_regs();
      wr(24'h11a5c3);
      wr(24'h1cfffe);
      wr(24'h23ffe0);
      wr(24'h2812d8);
      `CHK(cfg[1].code, 16'ha5c3)
      `CHK(cfg[2].code, 16'h0000)
      for (int c = 0; c < 4; c++) `CHK(cfg[c].range, 2'h2)
      `CHK(cfg[3].gain, 6'h20)
      `CHK(cfg[0].offs, 8'hd8)
   endtask
   // undefined codes, bad bit 22, nop and range 11 must change nothing
   task automatic t_refuse();
      wr(24'h180003);
      wr(24'h08ffff);
      wr(24'h510000);
      wr(24'h151111);
      wr(24'h00ffff);
      wr(24'h03ffff);
      wr(24'h07ffff);
      host.frame(24'h11ffff, 23, rx);
      `CHK(cfg[0], {16'h0000, 2'h2, 6'h00, 8'hd8})
      `CHK(cfg[1].code, 16'ha5c3)
      `CHK({lgo, sdo_oe_n, pin_oe_n}, 4'b0011)
      `CHK(n_load + n_clear, 0)
   endtask
   // value bits only follow writes while the pin is an output
   task automatic t_func();
      wr(24'h01003f);
      `CHK({lgo, pin_oe_n, pin_o, sdo_oe_n}, 6'b100111)
      wr(24'h010000);
      `CHK({lgo, pin_oe_n, pin_o, sdo_oe_n}, 6'b011110)
      wr(24'h810000);
      wr(24'h000000);
      `CHK(rx, 24'h810008)
   endtask
   // clear must not touch the input registers
   task automatic t_loadclr();
      wr(24'h101234);
      wr(24'h050000);
      `CHK(dac[0], 16'h1234)
      `CHK(dac[1], 16'ha5c3)
      `CHK(n_load, 1)
      wr(24'h04ffff);
      `CHK(dac, {4{CLEAR_CODE}})
      `CHK(cfg[0].code, 16'h1234)
      `CHK(n_clear, 1)
   endtask
   // per-channel registers read back, each answer shifted out by the next frame
   task automatic t_readback();
      wr(24'h910000);
      wr(24'ha30000);
      `CHK(rx, 24'h91a5c3)
      wr(24'ha80000);
      `CHK(rx, 24'ha30020)
      wr(24'h000000);
      `CHK(rx, 24'ha800d8)
   endtask
   task automatic finish_test();
      if (num_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // a hang counts as a mismatch
   initial begin
      #400000;
      num_errors++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      #1;
      nrst_i = 1'b1;
      host.tick(6);
      t_reset();
      t_regs();
      t_refuse();
      t_func();
      t_loadclr();
      t_readback();
      finish_test();
   end
endmodule
`default_nettype wire
